// ---- inc/sqc_consts.vh ----
`ifndef SQC_CONSTS_VH
`define SQC_CONSTS_VH
// Register indices; the byte address is four times the index
`define SQC_IDX_GCTL_A 20'h30005
`define SQC_IDX_TSEL_A 20'h30006
`define SQC_IDX_CCTL_AC 20'h30024
`define SQC_IDX_GCTL_B 20'h30105
`define SQC_IDX_TSEL_B 20'h30106
`define SQC_IDX_CCTL_BC 20'h30124
`define SQC_IDX_CCTL_BD 20'h30134
`define SQC_IDX_SYNC_A 20'h30800
`define SQC_IDX_LOOP_A 20'h30801
`define SQC_IDX_XSTAT_A 20'h30804
`define SQC_IDX_AMODE_A 20'h30811
`define SQC_IDX_RSYN_A 20'h30820
`define SQC_IDX_BYP_A 20'h30821
`define SQC_IDX_SYNC_B 20'h30900
`define SQC_IDX_LOOP_B 20'h30901
`define SQC_IDX_XSTAT_B 20'h30904
`define SQC_IDX_REALN 20'h30910
`define SQC_IDX_AMODE_B 20'h30911
`define SQC_IDX_RSYN_B 20'h30920
`define SQC_IDX_BYP_B 20'h30921
`define SQC_IDX_CHARZ 20'h30933
// Writable masks and reset values
`define SQC_GCTL_WMASK 8'h9e
`define SQC_GCTL_RST 8'h22
`define SQC_TSEL_WMASK 8'h1f
`define SQC_CCTL_WMASK 8'h86
`define SQC_CCTL_RST 8'h02
`define SQC_BYP_WMASK 8'h01
`define SQC_CHARZ_WMASK 8'hf0
`define SQC_ZERO8 8'h00
// Field positions
`define SQC_B_MASK 1
`define SQC_B_SRST 2
`define SQC_B_TXPD 3
`define SQC_B_RXPD 4
`define SQC_B_GTEST 7
`define SQC_B_XAUI 7
`define SQC_B_CZDIR 6
`define SQC_B_CZEN 7
`define SQC_PULSE_LEN 4'h1
`endif

// ---- hw/sqc_edge_det.v ----
`timescale 1ns/1ps
// ****************************************
// Rising edge pulse for a register field
// ****************************************
module sqc_edge_det #(
  parameter WIDTH = 8
) (
  input wire mclk_i,
  input wire nrst_i,
  input wire [WIDTH-1:0] level_i,
  output reg [WIDTH-1:0] pulse_o
);
  reg [WIDTH-1:0] last_reg;
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      last_reg <= {WIDTH{1'b0}};
      pulse_o <= {WIDTH{1'b0}};
    end else begin
      last_reg <= level_i;
      pulse_o <= level_i & ~last_reg;
    end
  end
endmodule // sqc_edge_det

// ---- hw/sqc_sync2.v ----
`timescale 1ns/1ps
// ****************************************
// Two-flop synchroniser
// ****************************************
module sqc_sync2 #(
  parameter WIDTH = 16
) (
  input wire mclk_i,
  input wire nrst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_reg;
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule // sqc_sync2

// ---- hw/sqc_regs.v ----
// Operation
// - channel mask blocks that channel's alarm interrupts
// - channel mask overrides individual alarm masks
// - channel soft reset resets datapath, keeps config
// - channel or block test enable enters test
// - block mask blocks alarms of its four channels
// - block soft reset overrides channel resets
// - block powerdown bits override channel powerdown
// - five-bit test select field, rest reserved
// - byte sync enable per channel, bits 0-3
// - lock select; lock flag zero when ref
// - loopback routes tx to rx, silences output
// - word align disable per channel
// - realign rising edge realigns at next comma
// - channel joins alignment only when enabled
// - two-bit alignment group mode decode
// - single resync rising edge resets pointers
// - pair and quad resync rising edges
// - block XAUI bit overrides link selects
// - bypass bit routes around alignment FIFOs
// - characterization channel, direction, enable decode
// - read-only XAUI link status field
`timescale 1ns/1ps
`include "sqc_consts.vh"
module sqc_regs (
  input wire mclk_i,
  input wire nrst_i,
  input wire hsel_i,
  input wire [19:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  input wire [15:0] xaui_link_state_i,
  input wire [7:0] rx_pll_lock_raw_i,
  input wire [7:0] chan_alarm_i,
  input wire [7:0] chan_tx_powerdown_i,
  input wire [7:0] chan_rx_powerdown_i,
  input wire [7:0] fc_link_machine_select_i,
  output reg [7:0] alarm_irq_o,
  output reg [7:0] chan_datapath_reset_o,
  output reg [7:0] tx_powerdown_o,
  output reg [7:0] rx_powerdown_o,
  output reg [7:0] test_mode_o,
  output reg [9:0] test_select_o,
  output reg [7:0] rx_byte_sync_enable_o,
  output reg [7:0] rx_lock_to_data_select_o,
  output reg [7:0] rx_pll_lock_flag_o,
  output reg [7:0] serial_loopback_enable_o,
  output reg [7:0] serial_output_enable_o,
  output reg [7:0] word_align_disable_o,
  output reg [7:0] word_realign_pulse_o,
  output reg [7:0] multichan_align_join_o,
  output reg [7:0] align_none_o,
  output reg [7:0] align_twin_o,
  output reg [7:0] align_quad_o,
  output reg [7:0] align_eight_o,
  output reg [7:0] align_ptr_reset_o,
  output reg [7:0] xaui_machine_enable_o,
  output reg [1:0] align_fifo_bypass_o,
  output reg [3:0] charz_channel_onehot_o,
  output reg charz_tx_select_o,
  output reg charz_enable_o
);
  // ****************************************
  // Register storage
  // ****************************************
  reg [7:0] gctl_reg [0:1];
  reg [7:0] tsel_reg [0:1];
  reg [7:0] cctl_reg [0:7];
  reg [7:0] sync_reg [0:1];
  reg [7:0] loop_reg [0:1];
  reg [7:0] amode_reg [0:1];
  reg [7:0] rsyn_reg [0:1];
  reg [7:0] byp_reg [0:1];
  reg [7:0] realn_reg;
  reg [7:0] charz_reg;
  reg wr_pend_reg;
  reg [19:0] wr_addr_reg;
  wire [15:0] xstat_s;
  wire [7:0] lock_s;
  wire [7:0] alarm_s;
  wire [7:0] realn_edge;
  wire [7:0] rsyn_edge_a;
  wire [7:0] rsyn_edge_b;
  integer i;
  integer k;

  // Status, lock and alarm pins come from outside the clock
  sqc_sync2 #(.WIDTH(16)) u_sync_xstat (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i(xaui_link_state_i),
    .sync_o(xstat_s)
  );
  sqc_sync2 #(.WIDTH(16)) u_sync_misc (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i({rx_pll_lock_raw_i, chan_alarm_i}),
    .sync_o({lock_s, alarm_s})
  );

  // ****************************************
  // Address decode
  // ****************************************
  // Maps a register index to one of eight-bit registers
  function [7:0] rd_sel;
    input [19:0] a;
    begin
      case (a)
        `SQC_IDX_GCTL_A: rd_sel = gctl_reg[0];
        `SQC_IDX_GCTL_B: rd_sel = gctl_reg[1];
        `SQC_IDX_TSEL_A: rd_sel = tsel_reg[0];
        `SQC_IDX_TSEL_B: rd_sel = tsel_reg[1];
        `SQC_IDX_CCTL_AC: rd_sel = cctl_reg[2];
        `SQC_IDX_CCTL_BC: rd_sel = cctl_reg[6];
        `SQC_IDX_CCTL_BD: rd_sel = cctl_reg[7];
        `SQC_IDX_SYNC_A: rd_sel = sync_reg[0];
        `SQC_IDX_SYNC_B: rd_sel = sync_reg[1];
        `SQC_IDX_LOOP_A: rd_sel = loop_reg[0];
        `SQC_IDX_LOOP_B: rd_sel = loop_reg[1];
        `SQC_IDX_XSTAT_A: rd_sel = xstat_s[7:0];
        `SQC_IDX_XSTAT_B: rd_sel = xstat_s[15:8];
        `SQC_IDX_AMODE_A: rd_sel = amode_reg[0];
        `SQC_IDX_AMODE_B: rd_sel = amode_reg[1];
        `SQC_IDX_RSYN_A: rd_sel = rsyn_reg[0];
        `SQC_IDX_RSYN_B: rd_sel = rsyn_reg[1];
        `SQC_IDX_BYP_A: rd_sel = byp_reg[0];
        `SQC_IDX_BYP_B: rd_sel = byp_reg[1];
        `SQC_IDX_REALN: rd_sel = realn_reg;
        `SQC_IDX_CHARZ: rd_sel = charz_reg;
        default: rd_sel = `SQC_ZERO8;
      endcase
    end
  endfunction

  // Byte address = register index times four
  wire [19:0] a_idx = {2'b00, haddr_i[19:2]};
  wire [19:0] w_idx = {2'b00, wr_addr_reg[19:2]};
  wire take = hsel_i & hready_i & htrans_i[1];

  // ****************************************
  // Bus slave and register writes
  // ****************************************
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 20'h00000;
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      gctl_reg[0] <= `SQC_GCTL_RST;
      gctl_reg[1] <= `SQC_GCTL_RST;
      tsel_reg[0] <= `SQC_ZERO8;
      tsel_reg[1] <= `SQC_ZERO8;
      for (k = 0; k < 8; k = k + 1) begin
        cctl_reg[k] <= `SQC_CCTL_RST;
      end
      for (k = 0; k < 2; k = k + 1) begin
        sync_reg[k] <= `SQC_ZERO8;
        loop_reg[k] <= `SQC_ZERO8;
        amode_reg[k] <= `SQC_ZERO8;
        rsyn_reg[k] <= `SQC_ZERO8;
        byp_reg[k] <= `SQC_ZERO8;
      end
      realn_reg <= `SQC_ZERO8;
      charz_reg <= `SQC_ZERO8;
    end else begin
      wr_pend_reg <= take & hwrite_i;
      if (take) begin
        wr_addr_reg <= haddr_i;
      end
      if (take & ~hwrite_i) begin
        // Decoded at the address-phase edge; a write landing on that same edge is not seen
        hrdata_o <= {24'h000000, rd_sel(a_idx)};
      end
      if (wr_pend_reg) begin
        case (w_idx)
          `SQC_IDX_GCTL_A: gctl_reg[0] <= (hwdata_i[7:0] &
            `SQC_GCTL_WMASK) | (`SQC_GCTL_RST & ~`SQC_GCTL_WMASK);
          `SQC_IDX_GCTL_B: gctl_reg[1] <= (hwdata_i[7:0] &
            `SQC_GCTL_WMASK) | (`SQC_GCTL_RST & ~`SQC_GCTL_WMASK);
          `SQC_IDX_TSEL_A: tsel_reg[0] <= hwdata_i[7:0] & `SQC_TSEL_WMASK;
          `SQC_IDX_TSEL_B: tsel_reg[1] <= hwdata_i[7:0] & `SQC_TSEL_WMASK;
          `SQC_IDX_CCTL_AC: cctl_reg[2] <= hwdata_i[7:0] & `SQC_CCTL_WMASK;
          `SQC_IDX_CCTL_BC: cctl_reg[6] <= hwdata_i[7:0] & `SQC_CCTL_WMASK;
          `SQC_IDX_CCTL_BD: cctl_reg[7] <= hwdata_i[7:0] & `SQC_CCTL_WMASK;
          `SQC_IDX_SYNC_A: sync_reg[0] <= hwdata_i[7:0];
          `SQC_IDX_SYNC_B: sync_reg[1] <= hwdata_i[7:0];
          `SQC_IDX_LOOP_A: loop_reg[0] <= hwdata_i[7:0];
          `SQC_IDX_LOOP_B: loop_reg[1] <= hwdata_i[7:0];
          `SQC_IDX_AMODE_A: amode_reg[0] <= hwdata_i[7:0];
          `SQC_IDX_AMODE_B: amode_reg[1] <= hwdata_i[7:0];
          `SQC_IDX_RSYN_A: rsyn_reg[0] <= hwdata_i[7:0];
          `SQC_IDX_RSYN_B: rsyn_reg[1] <= hwdata_i[7:0];
          `SQC_IDX_BYP_A: byp_reg[0] <= hwdata_i[7:0] & `SQC_BYP_WMASK;
          `SQC_IDX_BYP_B: byp_reg[1] <= hwdata_i[7:0] & `SQC_BYP_WMASK;
          `SQC_IDX_REALN: realn_reg <= hwdata_i[7:0];
          `SQC_IDX_CHARZ: charz_reg <= hwdata_i[7:0] & `SQC_CHARZ_WMASK;
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // Trigger edge detection
  // ****************************************
  // realign edge
  sqc_edge_det #(.WIDTH(8)) u_edge_realn (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .level_i(realn_reg),
    .pulse_o(realn_edge)
  );
  sqc_edge_det #(.WIDTH(8)) u_edge_rsyn_a (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .level_i(rsyn_reg[0]),
    .pulse_o(rsyn_edge_a)
  );
  sqc_edge_det #(.WIDTH(8)) u_edge_rsyn_b (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .level_i(rsyn_reg[1]),
    .pulse_o(rsyn_edge_b)
  );

  // ****************************************
  // Per-channel control outputs
  // ****************************************
  // Channel c: quad q = c/4, lane l = c%4
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      alarm_irq_o <= 8'h00;
      chan_datapath_reset_o <= 8'hff;
      tx_powerdown_o <= 8'h00;
      rx_powerdown_o <= 8'h00;
      test_mode_o <= 8'h00;
      test_select_o <= 10'h000;
      rx_byte_sync_enable_o <= 8'h00;
      rx_lock_to_data_select_o <= 8'h00;
      rx_pll_lock_flag_o <= 8'h00;
      serial_loopback_enable_o <= 8'h00;
      serial_output_enable_o <= 8'hff;
      word_align_disable_o <= 8'h00;
      word_realign_pulse_o <= 8'h00;
      multichan_align_join_o <= 8'h00;
      align_none_o <= 8'hff;
      align_twin_o <= 8'h00;
      align_quad_o <= 8'h00;
      align_eight_o <= 8'h00;
      align_ptr_reset_o <= 8'h00;
      xaui_machine_enable_o <= 8'h00;
      align_fifo_bypass_o <= 2'b00;
      charz_channel_onehot_o <= 4'h0;
      charz_tx_select_o <= 1'b0;
      charz_enable_o <= 1'b0;
    end else begin
      test_select_o <= {tsel_reg[1][4:0], tsel_reg[0][4:0]};
      for (i = 0; i < 8; i = i + 1) begin
        alarm_irq_o[i] <= alarm_s[i] & ~cctl_reg[i][`SQC_B_MASK] &
          ~gctl_reg[i/4][`SQC_B_MASK];
        chan_datapath_reset_o[i] <= cctl_reg[i][`SQC_B_SRST] |
          gctl_reg[i/4][`SQC_B_SRST];
        tx_powerdown_o[i] <= chan_tx_powerdown_i[i] |
          gctl_reg[i/4][`SQC_B_TXPD];
        rx_powerdown_o[i] <= chan_rx_powerdown_i[i] |
          gctl_reg[i/4][`SQC_B_RXPD];
        test_mode_o[i] <= cctl_reg[i][7] | gctl_reg[i/4][`SQC_B_GTEST];
        rx_byte_sync_enable_o[i] <= sync_reg[i/4][i%4];
        rx_lock_to_data_select_o[i] <= sync_reg[i/4][4+i%4];
        rx_pll_lock_flag_o[i] <= lock_s[i] & sync_reg[i/4][4+i%4];
        serial_loopback_enable_o[i] <= loop_reg[i/4][i%4];
        serial_output_enable_o[i] <= ~loop_reg[i/4][i%4];
        word_align_disable_o[i] <= loop_reg[i/4][4+i%4];
        word_realign_pulse_o[i] <= (i < 4) ? realn_edge[i%4] : 1'b0;
        multichan_align_join_o[i] <= (i < 4) ? realn_reg[4+i%4] : 1'b0;
        // mode decode, first bit is lsb
        align_none_o[i] <= amode_reg[i/4][2*(i%4)+:2] == 2'b00;
        align_twin_o[i] <= amode_reg[i/4][2*(i%4)+:2] == 2'b01;
        align_quad_o[i] <= amode_reg[i/4][2*(i%4)+:2] == 2'b10;
        align_eight_o[i] <= amode_reg[i/4][2*(i%4)+:2] == 2'b11;
        align_ptr_reset_o[i] <= (i < 4) ?
          (rsyn_edge_a[i%4] | rsyn_edge_a[4 + (i%4)/2] | rsyn_edge_a[6]) :
          (rsyn_edge_b[i%4] | rsyn_edge_b[4 + (i%4)/2] | rsyn_edge_b[6]);
        xaui_machine_enable_o[i] <= rsyn_reg[i/4][`SQC_B_XAUI] |
          ~fc_link_machine_select_i[i];
      end
      align_fifo_bypass_o <= {byp_reg[1][0], byp_reg[0][0]};
      // characterization decode, bit 4 is first
      case (charz_reg[5:4])
        2'b00: charz_channel_onehot_o <= 4'h1;
        2'b01: charz_channel_onehot_o <= 4'h2;
        2'b10: charz_channel_onehot_o <= 4'h4;
        default: charz_channel_onehot_o <= 4'h8;
      endcase
      charz_tx_select_o <= charz_reg[`SQC_B_CZDIR];
      charz_enable_o <= charz_reg[`SQC_B_CZEN];
    end
  end
endmodule // sqc_regs

// ---- verification/sqc_regs_assertions.sv ----
`timescale 1ns/1ps
// ****************************************
// Port checker for the register bank
// ****************************************
module sqc_regs_assertions (
  input logic mclk_i,
  input logic nrst_i,
  input logic hreadyout_o,
  input logic hresp_o,
  input logic [7:0] chan_tx_powerdown_i,
  input logic [7:0] fc_link_machine_select_i,
  input logic [7:0] tx_powerdown_o,
  input logic [7:0] rx_pll_lock_flag_o,
  input logic [7:0] rx_lock_to_data_select_o,
  input logic [7:0] serial_loopback_enable_o,
  input logic [7:0] serial_output_enable_o,
  input logic [7:0] word_realign_pulse_o,
  input logic [7:0] align_ptr_reset_o,
  input logic [7:0] align_none_o,
  input logic [7:0] align_twin_o,
  input logic [7:0] align_quad_o,
  input logic [7:0] align_eight_o,
  input logic [7:0] xaui_machine_enable_o,
  input logic [3:0] charz_channel_onehot_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  // Two live cycles, so $past sees no reset value
  sequence s_live;
    $past(nrst_i) && nrst_i;
  endsequence
  sequence s_realign_fired;
    word_realign_pulse_o != 8'h00;
  endsequence
  sequence s_ptr_fired;
    align_ptr_reset_o != 8'h00;
  endsequence
  AST_AHB_OKAY: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  AST_LOOP_SILENCE: assert property (
    serial_output_enable_o == ~serial_loopback_enable_o)
    else $error("serial output on during loopback");
  AST_LOCK_FLAG: assert property (
    (rx_pll_lock_flag_o & ~rx_lock_to_data_select_o) == 8'h00)
    else $error("lock flag set while locked to reference");
  AST_MODE_ONE: assert property (
    ((align_none_o | align_twin_o | align_quad_o | align_eight_o)
      == 8'hff) && (((align_none_o & (align_twin_o | align_quad_o
      | align_eight_o)) | (align_twin_o & (align_quad_o
      | align_eight_o)) | (align_quad_o & align_eight_o)) == 8'h00))
    else $error("alignment mode decode not one per channel");
  AST_REALIGN_ONE: assert property (s_realign_fired |=>
    (word_realign_pulse_o & $past(word_realign_pulse_o)) == 8'h00)
    else $error("realign pulse longer than one cycle");
  AST_PTR_ONE: assert property (s_ptr_fired |=>
    (align_ptr_reset_o & $past(align_ptr_reset_o)) == 8'h00)
    else $error("pointer reset pulse longer than one cycle");
  AST_TX_PWRDN: assert property (s_live |->
    ($past(chan_tx_powerdown_i) & ~tx_powerdown_o) == 8'h00)
    else $error("channel tx powerdown not passed on");
  AST_XAUI_SEL: assert property (s_live |->
    (~$past(fc_link_machine_select_i) & ~xaui_machine_enable_o)
      == 8'h00)
    else $error("xaui machine off without fc select");
  AST_CHARZ_SEL: assert property ($onehot0(charz_channel_onehot_o))
    else $error("characterization channel select not one-hot");
endmodule // sqc_regs_assertions

bind sqc_regs sqc_regs_assertions u_sqc_chk (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .chan_tx_powerdown_i(chan_tx_powerdown_i),
  .fc_link_machine_select_i(fc_link_machine_select_i),
  .tx_powerdown_o(tx_powerdown_o),
  .rx_pll_lock_flag_o(rx_pll_lock_flag_o),
  .rx_lock_to_data_select_o(rx_lock_to_data_select_o),
  .serial_loopback_enable_o(serial_loopback_enable_o),
  .serial_output_enable_o(serial_output_enable_o),
  .word_realign_pulse_o(word_realign_pulse_o),
  .align_ptr_reset_o(align_ptr_reset_o), .align_none_o(align_none_o),
  .align_twin_o(align_twin_o), .align_quad_o(align_quad_o),
  .align_eight_o(align_eight_o),
  .xaui_machine_enable_o(xaui_machine_enable_o),
  .charz_channel_onehot_o(charz_channel_onehot_o)
);

// ---- verification/sqc_regs_tb.sv ----
`timescale 1ns/1ps
`include "sqc_consts.vh"
module sqc_regs_tb;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [19:0] haddr_i = 20'h00000;
  logic [1:0] htrans_i = 2'b00;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'b010;
  logic [31:0] hwdata_i = 32'h00000000;
  logic [15:0] xst = 16'h0000;
  logic [7:0] lraw = 8'h5a, alm = 8'hff, txpd = 8'h00, rxpd = 8'h00;
  logic [7:0] fcs = 8'h00, wseen = 8'h00, pseen = 8'h00;
  wire hready_i;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hresp_o, cztx, czen;
  wire [7:0] irq, dprst, txpd_o, rxpd_o, tmode, bsync, lsel, lflag;
  wire [7:0] lpbk, soen, wad, wrp, join_o, an, at, aq, ae, prst, xen;
  wire [9:0] tsel;
  wire [1:0] byp;
  wire [3:0] czch;
  int err_count = 0;
  int cmp_count = 0;
  int i;
  logic [19:0] ra [22] = '{`SQC_IDX_GCTL_A, `SQC_IDX_TSEL_A,
    `SQC_IDX_CCTL_AC, `SQC_IDX_GCTL_B, `SQC_IDX_TSEL_B, `SQC_IDX_CCTL_BC,
    `SQC_IDX_CCTL_BD, `SQC_IDX_SYNC_A, `SQC_IDX_LOOP_A, `SQC_IDX_XSTAT_A,
    `SQC_IDX_AMODE_A, `SQC_IDX_RSYN_A, `SQC_IDX_BYP_A, `SQC_IDX_SYNC_B,
    `SQC_IDX_LOOP_B, `SQC_IDX_XSTAT_B, `SQC_IDX_REALN, `SQC_IDX_AMODE_B,
    `SQC_IDX_RSYN_B, `SQC_IDX_BYP_B, `SQC_IDX_CHARZ, 20'h30007};
  logic [7:0] rr [22] = '{8'h22, 8'h00, 8'h02, 8'h22, 8'h00, 8'h02,
    8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] rm [22] = '{8'h9e, 8'h1f, 8'h86, 8'h9e, 8'h1f, 8'h86,
    8'h86, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff,
    8'h00, 8'hff, 8'hff, 8'hff, 8'h01, 8'hf0, 8'h00};
  logic [7:0] pe [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h03, 8'h0c, 8'h0f};

  assign hready_i = hreadyout_o;
  sqc_regs dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .xaui_link_state_i(xst), .rx_pll_lock_raw_i(lraw), .chan_alarm_i(alm),
    .chan_tx_powerdown_i(txpd), .chan_rx_powerdown_i(rxpd),
    .fc_link_machine_select_i(fcs), .alarm_irq_o(irq),
    .chan_datapath_reset_o(dprst), .tx_powerdown_o(txpd_o),
    .rx_powerdown_o(rxpd_o), .test_mode_o(tmode), .test_select_o(tsel),
    .rx_byte_sync_enable_o(bsync), .rx_lock_to_data_select_o(lsel),
    .rx_pll_lock_flag_o(lflag), .serial_loopback_enable_o(lpbk),
    .serial_output_enable_o(soen), .word_align_disable_o(wad),
    .word_realign_pulse_o(wrp), .multichan_align_join_o(join_o),
    .align_none_o(an), .align_twin_o(at), .align_quad_o(aq),
    .align_eight_o(ae), .align_ptr_reset_o(prst),
    .xaui_machine_enable_o(xen), .align_fifo_bypass_o(byp),
    .charz_channel_onehot_o(czch), .charz_tx_select_o(cztx),
    .charz_enable_o(czen));

  // ****************************************
  // Clock, pulse catcher, bus tasks
  // ****************************************
  initial forever #12.5 mclk_i = ~mclk_i;
  always @(negedge mclk_i) begin
    wseen = wseen | wrp;
    pseen = pseen | prst;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Entered just after an edge; holds each phase until hready
  task automatic xfer(input logic [19:0] a, input logic w,
      input logic [7:0] d, output logic [31:0] r);
    hsel_i <= 1'b1;
    haddr_i <= a << 2;
    hwrite_i <= w;
    htrans_i <= 2'b10;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    #1;
    htrans_i <= 2'b00;
    hwdata_i <= {24'h000000, d};
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
    #1;
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic rdc(input logic [19:0] a, input logic [7:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 8'h00, r);
    chk("hrdata", {24'h000000, e}, r);
  endtask
  task automatic outs(input logic [31:0] a, b, c, input logic [27:0] d);
    chk("irq_rst_pd", a, {irq, dprst, txpd_o, rxpd_o});
    chk("test_sync_lock", b, {tmode, bsync, lsel, lflag});
    chk("loop_align", c, {lpbk, soen, wad, join_o});
    chk("mode_xaui_sel", {4'h0, d}, {4'h0, ae, xen, tsel, byp});
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    err_count++;
    tally_and_finish;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    cyc(1);
    for (i = 0; i < 22; i++) rdc(ra[i], rr[i]);
    chk("irq_rst", 16'h0000, {irq, dprst});
    wseen = 8'h00;
    pseen = 8'h00;
    for (i = 0; i < 22; i++) wr(ra[i], 8'hff);
    cyc(6);
    chk("pulses", 16'h0fff, {wseen, pseen});
    for (i = 0; i < 22; i++) rdc(ra[i], rm[i] | rr[i]);
    outs(32'h00ffffff, 32'hffffff5a, 32'hff00ff0f, 28'hfffffff); // 20
    txpd <= 8'h33;
    rxpd <= 8'hcc;
    fcs <= 8'h0f;
    wseen = 8'h00;
    pseen = 8'h00;
    for (i = 0; i < 22; i++) wr(ra[i], 8'h00);
    cyc(6);
    chk("no_pulse", 16'h0000, {wseen, pseen});
    for (i = 0; i < 22; i++) rdc(ra[i], rr[i] & ~rm[i]);
    outs(32'hc40033cc, 32'h0, 32'h00ff0000, 28'h00f0000);
    wr(`SQC_IDX_CCTL_AC, 8'h02);
    alm <= 8'h44;
    cyc(6);
    chk("irq", 8'h40, irq);
    wr(`SQC_IDX_GCTL_B, 8'h02);
    cyc(3);
    chk("irq", 8'h00, irq);
    wr(`SQC_IDX_GCTL_B, 8'h00);
    wr(`SQC_IDX_CCTL_BD, 8'h84);
    cyc(3);
    chk("rst_test", 16'h8080, {dprst, tmode});
    wr(`SQC_IDX_GCTL_A, 8'h84);
    cyc(20);
    chk("rst_test", 16'h8f8f, {dprst, tmode});
    rdc(`SQC_IDX_CCTL_AC, 8'h02);
    wr(`SQC_IDX_GCTL_A, 8'h00);
    wr(`SQC_IDX_CCTL_BD, 8'h00);
    cyc(3);
    chk("rst_test", 16'h0000, {dprst, tmode});
    for (i = 0; i < 4; i++) begin
      wr(`SQC_IDX_AMODE_A, {4{i[1:0]}});
      wr(`SQC_IDX_AMODE_B, {4{i[1:0]}});
      cyc(3);
      chk("amode", 32'hff << (8 * i), {ae, aq, at, an});
    end
    for (i = 0; i < 7; i++) begin
      wr(`SQC_IDX_RSYN_A, 8'h00);
      pseen = 8'h00;
      wr(`SQC_IDX_RSYN_A, 8'h01 << i);
      wr(`SQC_IDX_RSYN_A, 8'h01 << i);
      cyc(6);
      chk("resync", pe[i], pseen);
    end
    wseen = 8'h00;
    wr(`SQC_IDX_REALN, 8'h25);
    cyc(6);
    chk("realign_join", 16'h0502, {wseen, join_o});
    for (i = 0; i < 4; i++) begin
      wr(`SQC_IDX_CHARZ, {1'b1, i[0], i[1:0], 4'hf});
      cyc(3);
      chk("charz", {4'b0001 << i, i[0], 1'b1}, {czch, cztx, czen});
    end
    wr(`SQC_IDX_SYNC_A, 8'h30);
    xst <= 16'h1b4e;
    cyc(6);
    chk("lock", 16'h0302, {lsel, lflag});
    wr(`SQC_IDX_XSTAT_A, 8'h00);
    rdc(`SQC_IDX_XSTAT_A, 8'h4e);
    rdc(`SQC_IDX_XSTAT_B, 8'h1b);
    tally_and_finish;
  end
endmodule // sqc_regs_tb
